// [design/uart_channel_pkg.sv]
// constants for the single-channel asynchronous receiver/transmitter
package uart_channel_pkg;
  // 4-bit register addresses on the 8-bit parallel port
  localparam logic [3:0] ADDR_MODE = 4'h0;
  localparam logic [3:0] ADDR_STATUS_BAUD = 4'h1;
  localparam logic [3:0] ADDR_COMMAND = 4'h2;
  localparam logic [3:0] ADDR_HOLDING = 4'h3;
  localparam logic [3:0] ADDR_PIN_CONFIG = 4'hD;
  localparam logic [3:0] ADDR_SET_OUT = 4'hE;
  localparam logic [3:0] ADDR_CLR_OUT = 4'hF;
  // channel_mode_first fields
  localparam int MODE1_RTS_CTRL = 7;
  localparam int MODE1_INT_SEL = 6;
  localparam int MODE1_ERR_MODE = 5;
  localparam int MODE1_PAR_HI = 4;
  localparam int MODE1_PAR_LO = 3;
  localparam int MODE1_PAR_TYPE = 2;
  localparam int MODE1_LEN_HI = 1;
  localparam int MODE1_LEN_LO = 0;
  // channel_mode_second fields
  localparam int MODE2_CTS_EN = 4;
  // parity mode encodings
  localparam logic [1:0] PAR_WITH = 2'h0;
  localparam logic [1:0] PAR_FORCE = 2'h1;
  localparam logic [1:0] PAR_NONE = 2'h2;
  localparam logic [1:0] PAR_MULTIDROP = 2'h3;
  // channel_command fields and miscellaneous codes
  localparam int CMD_RX_EN = 0;
  localparam int CMD_RX_DIS = 1;
  localparam int CMD_TX_EN = 2;
  localparam int CMD_TX_DIS = 3;
  localparam int CMD_MISC_HI = 6;
  localparam int CMD_MISC_LO = 4;
  localparam logic [2:0] CMD_RESET_PTR = 3'h1;
  localparam logic [2:0] CMD_RESET_RX = 3'h2;
  localparam logic [2:0] CMD_RESET_TX = 3'h3;
  localparam logic [2:0] CMD_RESET_ERR = 3'h4;
  // output_pin_config field
  localparam int PINCFG_PIN4_INT = 4;
  // receive entry: status above data
  localparam int ENTRY_W = 11;
  localparam int ENTRY_PERR = 8;
  localparam int ENTRY_FERR = 9;
  localparam int ENTRY_BRK = 10;
  localparam int RX_FIFO_DEPTH = 8;
  // reset values
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] OUT_PORT_RESET = 8'h00;
  localparam logic [7:0] PINCFG_RESET = 8'h00;
  // bit timing
  localparam int CLK_HZ = 200_000_000;
  localparam int BAUD_BPS = 9600;
  localparam int BIT_CLKS = CLK_HZ / BAUD_BPS;
endpackage : uart_channel_pkg

// [design/uart_rx_fifo.sv]
// receive fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module uart_rx_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 8
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_clear,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [AW:0] count;
  } fifo_state_t;

  fifo_state_t st;
  fifo_state_t next_st;
  logic push;
  logic pop;

  assign o_in_ready = st.count != (AW+1)'(DEPTH);
  assign o_out_valid = st.count != '0;
  assign o_out_data = st.mem[st.rd];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.mem[st.wr] = i_in_data;
      next_st.wr = (st.wr == AW'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
    end
    if (pop)
      next_st.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
    next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
    if (i_clear)
    begin
      next_st.rd = '0;
      next_st.wr = '0;
      next_st.count = '0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      st <= '0;
    else
      st <= next_st;
  end
endmodule : uart_rx_fifo
`default_nettype wire

// [design/uart_channel_mode_control.sv]
// one uart channel: mode pointer, flow control, interrupt select, error modes
// Contract
// - mode access reaches first register when selected
// - pointer returns to first on reset/command
// - first-register access moves pointer to second
// - request-to-send follows output-port bit 0
// - full fifo plus start bit negates request-to-send
// - port bit kept; re-assert when space frees
// - mode bit 6 picks ready or full
// - selected condition drives pin four when configured
// - mode bit 5 picks error reporting mode
// - character mode: flags of top character only
// - block mode: flags ORed since error reset
// - parity field 11 selects multidrop wake-up
// - multidrop sends mode bit 2 as tag
// - disabled multidrop receiver keeps only address characters
`timescale 1ns/10ps
`default_nettype none
module uart_channel_mode_control #(
  parameter int BIT_CLKS = uart_channel_pkg::BIT_CLKS,
  parameter int FIFO_DEPTH = uart_channel_pkg::RX_FIFO_DEPTH
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_chip_sel_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  input wire logic i_rx_line,
  output logic o_tx_line,
  input wire logic i_clear_to_send_in_n,
  output logic o_request_to_send_out_n,
  output logic o_output_pin_four_n,
  output logic o_rx_irq
);
  localparam logic [15:0] BIT_LAST = 16'(BIT_CLKS - 1);
  localparam logic [15:0] HALF_LAST = 16'(BIT_CLKS / 2 - 1);
  localparam int EW = uart_channel_pkg::ENTRY_W;

  typedef enum logic [2:0] {LINE_IDLE, LINE_START, LINE_DATA, LINE_PARITY, LINE_STOP} line_st_t;

  typedef struct packed {
    logic [7:0] mode1;
    logic [7:0] mode2;
    logic ptr_second;
    logic [7:0] out_bits;
    logic [7:0] pin_cfg;
    logic rx_en;
    logic tx_en;
    logic [7:0] rdata;
    logic overrun;
    logic [2:0] block_err;
    logic rts_hold;
    line_st_t rx_st;
    logic [15:0] rx_cnt;
    logic [2:0] rx_idx;
    logic [7:0] rx_shift;
    logic rx_par;
    logic rx_pbit;
    logic held_valid;
    logic [EW-1:0] held;
    line_st_t tx_st;
    logic [15:0] tx_cnt;
    logic [2:0] tx_idx;
    logic [7:0] tx_shift;
    logic tx_par;
    logic tx_hold_valid;
    logic [7:0] tx_hold;
    logic tx_line;
  } chan_state_t;

  chan_state_t st;
  chan_state_t next_st;

  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic fifo_clear;
  logic [EW-1:0] fifo_top;

  logic rd_acc;
  logic wr_acc;
  logic [1:0] par_mode;
  logic multidrop;
  logic use_pbit;
  logic [2:0] last_idx;
  logic [2:0] top_err;
  logic [2:0] shown_err;
  logic [7:0] status;
  logic rx_cond;
  logic [7:0] rx_data;
  logic rx_ferr;
  logic rx_perr;
  logic rx_brk;
  logic rx_keep;
  logic [2:0] misc;

  assign rd_acc = !i_chip_sel_n && !i_rd_n;
  assign wr_acc = !i_chip_sel_n && !i_wr_n;
  assign par_mode = st.mode1[uart_channel_pkg::MODE1_PAR_HI:uart_channel_pkg::MODE1_PAR_LO];
  assign multidrop = par_mode == uart_channel_pkg::PAR_MULTIDROP;
  assign use_pbit = par_mode != uart_channel_pkg::PAR_NONE;
  // five to eight bits: last index is 4 plus the length field
  assign last_idx = 3'h4 + {1'b0, st.mode1[uart_channel_pkg::MODE1_LEN_HI:uart_channel_pkg::MODE1_LEN_LO]};
  assign misc = i_wdata[uart_channel_pkg::CMD_MISC_HI:uart_channel_pkg::CMD_MISC_LO];
  assign fifo_pop = rd_acc && i_addr == uart_channel_pkg::ADDR_HOLDING;
  assign fifo_clear = wr_acc && i_addr == uart_channel_pkg::ADDR_COMMAND
    && misc == uart_channel_pkg::CMD_RESET_RX;

  assign top_err = fifo_out_valid
    ? fifo_top[uart_channel_pkg::ENTRY_BRK:uart_channel_pkg::ENTRY_PERR] : 3'h0;
  // block mode adds everything that reached the top since the error reset
  assign shown_err = st.mode1[uart_channel_pkg::MODE1_ERR_MODE]
    ? (st.block_err | top_err) : top_err;
  assign status = {shown_err, st.overrun,
    !st.tx_hold_valid && st.tx_st == LINE_IDLE,
    st.tx_en && !st.tx_hold_valid, !fifo_in_ready, fifo_out_valid};
  assign rx_cond = st.mode1[uart_channel_pkg::MODE1_INT_SEL]
    ? !fifo_in_ready : fifo_out_valid;

  // fields of the character as it completes on the stop bit
  assign rx_data = 8'(st.rx_shift >> (2'h3 - st.mode1[1:0]));
  assign rx_ferr = !i_rx_line;
  assign rx_brk = rx_ferr && rx_data == 8'h00 && !(use_pbit && st.rx_pbit);
  always_comb
  begin
    case (par_mode)
      uart_channel_pkg::PAR_WITH:
        rx_perr = st.rx_par ^ st.rx_pbit ^ st.mode1[uart_channel_pkg::MODE1_PAR_TYPE];
      uart_channel_pkg::PAR_FORCE:
        rx_perr = st.rx_pbit ^ st.mode1[uart_channel_pkg::MODE1_PAR_TYPE];
      uart_channel_pkg::PAR_MULTIDROP:
        rx_perr = st.rx_pbit; // tag travels in the parity slot
      default:
        rx_perr = 1'b0;
    endcase
  end
  // disabled multidrop receiver still watches for address tags
  assign rx_keep = multidrop ? (st.rx_en || st.rx_pbit) : st.rx_en;

  uart_rx_fifo #(
    .WIDTH(EW),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_clear(fifo_clear),
    .i_in_valid(st.held_valid),
    .o_in_ready(fifo_in_ready),
    .i_in_data(st.held),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_top)
  );

  always_comb
  begin
    next_st = st;
    // register port
    if (rd_acc)
    begin
      case (i_addr)
        uart_channel_pkg::ADDR_MODE:
        begin
          next_st.rdata = st.ptr_second ? st.mode2 : st.mode1;
          next_st.ptr_second = 1'b1;
        end
        uart_channel_pkg::ADDR_STATUS_BAUD:
          next_st.rdata = status;
        uart_channel_pkg::ADDR_HOLDING:
          next_st.rdata = fifo_top[7:0];
        default:
          next_st.rdata = 8'h00;
      endcase
    end
    if (wr_acc)
    begin
      case (i_addr)
        uart_channel_pkg::ADDR_MODE:
        begin
          if (st.ptr_second)
            next_st.mode2 = i_wdata;
          else
            next_st.mode1 = i_wdata;
          next_st.ptr_second = 1'b1;
        end
        uart_channel_pkg::ADDR_COMMAND:
        begin
          if (i_wdata[uart_channel_pkg::CMD_RX_EN])
            next_st.rx_en = 1'b1;
          if (i_wdata[uart_channel_pkg::CMD_RX_DIS])
            next_st.rx_en = 1'b0;
          if (i_wdata[uart_channel_pkg::CMD_TX_EN])
            next_st.tx_en = 1'b1;
          if (i_wdata[uart_channel_pkg::CMD_TX_DIS])
            next_st.tx_en = 1'b0;
          case (misc)
            uart_channel_pkg::CMD_RESET_PTR:
              next_st.ptr_second = 1'b0;
            uart_channel_pkg::CMD_RESET_RX:
            begin
              next_st.rx_en = 1'b0;
              next_st.overrun = 1'b0;
              next_st.block_err = 3'h0;
              next_st.rts_hold = 1'b0;
              next_st.held_valid = 1'b0;
              next_st.rx_st = LINE_IDLE;
            end
            uart_channel_pkg::CMD_RESET_TX:
            begin
              next_st.tx_en = 1'b0;
              next_st.tx_hold_valid = 1'b0;
              next_st.tx_st = LINE_IDLE;
              next_st.tx_line = 1'b1;
            end
            uart_channel_pkg::CMD_RESET_ERR:
            begin
              next_st.overrun = 1'b0;
              next_st.block_err = 3'h0;
            end
            default:
              next_st.rx_en = next_st.rx_en;
          endcase
        end
        uart_channel_pkg::ADDR_HOLDING:
          if (st.tx_en && !st.tx_hold_valid)
          begin
            next_st.tx_hold = i_wdata;
            next_st.tx_hold_valid = 1'b1;
          end
        uart_channel_pkg::ADDR_PIN_CONFIG:
          next_st.pin_cfg = i_wdata;
        uart_channel_pkg::ADDR_SET_OUT:
          next_st.out_bits = st.out_bits | i_wdata;
        uart_channel_pkg::ADDR_CLR_OUT:
          next_st.out_bits = st.out_bits & ~i_wdata;
        default:
          next_st.pin_cfg = next_st.pin_cfg; // baud select accepted, rate fixed
      endcase
    end

    // error accumulation; the top character still counts after a reset
    next_st.block_err = next_st.block_err | top_err;
    // space in the fifo lifts the automatic negation
    if (fifo_in_ready)
      next_st.rts_hold = 1'b0;
    if (st.held_valid && fifo_in_ready)
      next_st.held_valid = 1'b0;

    // receiver
    if (st.rx_st != LINE_IDLE)
      next_st.rx_cnt = st.rx_cnt + 16'h0001;
    case (st.rx_st)
      LINE_IDLE:
        if (!i_rx_line)
        begin
          next_st.rx_st = LINE_START;
          next_st.rx_cnt = 16'h0000;
        end
      LINE_START:
        if (st.rx_cnt == HALF_LAST)
        begin
          next_st.rx_cnt = 16'h0000;
          next_st.rx_idx = 3'h0;
          next_st.rx_par = 1'b0;
          next_st.rx_pbit = 1'b0;
          next_st.rx_st = i_rx_line ? LINE_IDLE : LINE_DATA;
          if (!i_rx_line && !fifo_in_ready)
          begin
            if (st.mode1[uart_channel_pkg::MODE1_RTS_CTRL])
              next_st.rts_hold = 1'b1;
            if (st.held_valid)
              next_st.overrun = 1'b1;
          end
        end
      LINE_DATA:
        if (st.rx_cnt == BIT_LAST)
        begin
          next_st.rx_cnt = 16'h0000;
          next_st.rx_shift = {i_rx_line, st.rx_shift[7:1]};
          next_st.rx_par = st.rx_par ^ i_rx_line;
          next_st.rx_idx = st.rx_idx + 3'h1;
          if (st.rx_idx == last_idx)
            next_st.rx_st = use_pbit ? LINE_PARITY : LINE_STOP;
        end
      LINE_PARITY:
        if (st.rx_cnt == BIT_LAST)
        begin
          next_st.rx_cnt = 16'h0000;
          next_st.rx_pbit = i_rx_line;
          next_st.rx_st = LINE_STOP;
        end
      LINE_STOP:
        if (st.rx_cnt == BIT_LAST)
        begin
          next_st.rx_st = LINE_IDLE;
          // an unpushed held character is overwritten: overrun was flagged
          if (rx_keep)
          begin
            next_st.held = {rx_brk, rx_ferr, rx_perr, rx_data};
            next_st.held_valid = 1'b1;
          end
        end
      default:
        next_st.rx_st = LINE_IDLE;
    endcase

    // transmitter
    if (st.tx_st != LINE_IDLE)
      next_st.tx_cnt = st.tx_cnt + 16'h0001;
    case (st.tx_st)
      LINE_IDLE:
        if (st.tx_hold_valid && (!st.mode2[uart_channel_pkg::MODE2_CTS_EN]
            || !i_clear_to_send_in_n))
        begin
          next_st.tx_shift = st.tx_hold;
          next_st.tx_hold_valid = 1'b0;
          next_st.tx_idx = 3'h0;
          next_st.tx_par = 1'b0;
          next_st.tx_cnt = 16'h0000;
          next_st.tx_line = 1'b0;
          next_st.tx_st = LINE_START;
        end
      LINE_START:
        if (st.tx_cnt == BIT_LAST)
        begin
          next_st.tx_cnt = 16'h0000;
          next_st.tx_line = st.tx_shift[0];
          next_st.tx_st = LINE_DATA;
        end
      LINE_DATA:
        if (st.tx_cnt == BIT_LAST)
        begin
          next_st.tx_cnt = 16'h0000;
          next_st.tx_par = st.tx_par ^ st.tx_shift[0];
          next_st.tx_shift = {1'b0, st.tx_shift[7:1]};
          next_st.tx_idx = st.tx_idx + 3'h1;
          next_st.tx_line = st.tx_shift[1];
          if (st.tx_idx == last_idx)
          begin
            if (!use_pbit)
            begin
              next_st.tx_line = 1'b1;
              next_st.tx_st = LINE_STOP;
            end
            else
            begin
              next_st.tx_st = LINE_PARITY;
              if (par_mode == uart_channel_pkg::PAR_WITH)
                next_st.tx_line = st.tx_par ^ st.tx_shift[0]
                  ^ st.mode1[uart_channel_pkg::MODE1_PAR_TYPE];
              else
                next_st.tx_line = st.mode1[uart_channel_pkg::MODE1_PAR_TYPE];
            end
          end
        end
      LINE_PARITY:
        if (st.tx_cnt == BIT_LAST)
        begin
          next_st.tx_cnt = 16'h0000;
          next_st.tx_line = 1'b1;
          next_st.tx_st = LINE_STOP;
        end
      LINE_STOP:
        if (st.tx_cnt == BIT_LAST)
          next_st.tx_st = LINE_IDLE;
      default:
        next_st.tx_st = LINE_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st <= '0;
      st.mode1 <= uart_channel_pkg::MODE_RESET;
      st.mode2 <= uart_channel_pkg::MODE_RESET;
      st.ptr_second <= 1'b0;
      st.out_bits <= uart_channel_pkg::OUT_PORT_RESET;
      st.pin_cfg <= uart_channel_pkg::PINCFG_RESET;
      st.rx_st <= LINE_IDLE;
      st.tx_st <= LINE_IDLE;
      st.tx_line <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign o_rdata = st.rdata;
  assign o_tx_line = st.tx_line;
  // pins are active low: request-to-send is port bit 0 unless auto-negated, pin four is port bit 4 or the receive condition
  assign o_request_to_send_out_n = !(st.out_bits[0] && !st.rts_hold);
  assign o_output_pin_four_n = st.pin_cfg[uart_channel_pkg::PINCFG_PIN4_INT]
    ? !rx_cond : !st.out_bits[4];
  assign o_rx_irq = rx_cond;
endmodule : uart_channel_mode_control
`default_nettype wire

// [testbench/uart_channel_mode_control_monitor.sv]
// port checker for the channel mode control block
`timescale 1ns/10ps
`default_nettype none
module uart_channel_mode_control_monitor #(
  parameter int BIT_CLKS = 16
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_chip_sel_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic i_rx_line,
  input wire logic o_tx_line,
  input wire logic i_clear_to_send_in_n,
  input wire logic o_request_to_send_out_n,
  input wire logic o_output_pin_four_n,
  input wire logic o_rx_irq
);
  // start bit is confirmed half a bit in, plus a few cycles of register lag
  localparam int LAG = BIT_CLKS / 2 + 4;
  logic rd, wr, am, ptr2, p0, c4;
  logic [7:0] m1, m2;
  assign rd = !i_chip_sel_n && !i_rd_n;
  assign wr = !i_chip_sel_n && !i_wr_n;
  assign am = i_addr == uart_channel_pkg::ADDR_MODE;
  // shadow of the writable state, rebuilt from bus traffic only
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      {ptr2, p0, c4, m1, m2} <= '0;
    else
    begin
      if ((rd || wr) && am)
        ptr2 <= 1'b1;
      if (wr && i_addr == uart_channel_pkg::ADDR_COMMAND && i_wdata[6:4] == 3'h1)
        ptr2 <= 1'b0;
      if (wr && am && !ptr2)
        m1 <= i_wdata;
      if (wr && am && ptr2)
        m2 <= i_wdata;
      if (wr && i_addr == uart_channel_pkg::ADDR_SET_OUT && i_wdata[0])
        p0 <= 1'b1;
      if (wr && i_addr == uart_channel_pkg::ADDR_CLR_OUT && i_wdata[0])
        p0 <= 1'b0;
      if (wr && i_addr == uart_channel_pkg::ADDR_PIN_CONFIG)
        c4 <= i_wdata[4];
    end
  end
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);
  a_mode_first_read:
    assert property (rd && am && !ptr2 |=> o_rdata == m1) else $error("first mode read wrong");
  a_mode_second_read:
    assert property (rd && am && ptr2 |=> o_rdata == m2) else $error("second mode read wrong");
  a_rts_port_set:
    assert property (wr && i_addr == uart_channel_pkg::ADDR_SET_OUT && i_wdata[0] && !m1[7]
      |-> ##[1:2] !o_request_to_send_out_n) else $error("rts not asserted by port bit");
  a_rts_port_clear:
    assert property (wr && i_addr == uart_channel_pkg::ADDR_CLR_OUT && i_wdata[0]
      |-> ##[1:2] o_request_to_send_out_n) else $error("rts not negated by port bit");
  a_rts_auto_drop:
    assert property (m1[7] && m1[6] && o_rx_irq && p0 && $fell(i_rx_line)
      |-> ##[1:LAG] o_request_to_send_out_n) else $error("rts kept on with full fifo");
  a_rts_reassert:
    assert property (m1[7] && m1[6] && p0 && o_rx_irq && rd
      && i_addr == uart_channel_pkg::ADDR_HOLDING
      |-> ##[1:3] !o_request_to_send_out_n) else $error("rts not restored after pop");
  a_irq_status:
    assert property (rd && i_addr == uart_channel_pkg::ADDR_STATUS_BAUD
      |=> (m1[6] ? o_rdata[1] : o_rdata[0]) == $past(o_rx_irq))
      else $error("interrupt differs from selected status bit");
  a_pin4_irq:
    assert property (c4 && $past(c4) && $stable(o_rx_irq)
      |-> o_output_pin_four_n == !o_rx_irq) else $error("pin four not following irq");
endmodule : uart_channel_mode_control_monitor
bind uart_channel_mode_control uart_channel_mode_control_monitor #(.BIT_CLKS(BIT_CLKS))
  uart_channel_mode_control_monitor_inst (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
  .i_chip_sel_n(i_chip_sel_n), .i_rd_n(i_rd_n), .i_wr_n(i_wr_n), .i_addr(i_addr),
  .i_wdata(i_wdata), .o_rdata(o_rdata), .i_rx_line(i_rx_line), .o_tx_line(o_tx_line),
  .i_clear_to_send_in_n(i_clear_to_send_in_n),
  .o_request_to_send_out_n(o_request_to_send_out_n),
  .o_output_pin_four_n(o_output_pin_four_n), .o_rx_irq(o_rx_irq));
`default_nettype wire

// [testbench/uart_remote_end.sv]
// remote serial end: sends frames to the receiver, captures transmitted frames
`timescale 1ns/10ps
`default_nettype none
module uart_remote_end #(
  parameter int BIT_CLKS = 16
) (
  input wire logic i_core_clk,
  input wire logic i_tx_line,
  output logic o_rx_line,
  output logic o_cts_n
);
  initial
  begin
    o_rx_line = 1'b1;
    o_cts_n = 1'b0;
  end
  task automatic send(input logic [7:0] d, input int n, input logic hx, input logic x,
    input logic stop);
    @(posedge i_core_clk);
    o_rx_line <= 1'b0;
    repeat (BIT_CLKS) @(posedge i_core_clk);
    for (int i = 0; i < n + 32'(hx); i++)
    begin
      o_rx_line <= (i < n) ? d[i] : x;
      repeat (BIT_CLKS) @(posedge i_core_clk);
    end
    o_rx_line <= stop;
    repeat (BIT_CLKS) @(posedge i_core_clk);
    // idle mark gives the receiver time to store the character
    o_rx_line <= 1'b1;
    repeat (BIT_CLKS) @(posedge i_core_clk);
  endtask : send
  task automatic recv(input int n, input logic hx, output logic [7:0] d, output logic x,
    output logic stop);
    int k;
    d = 8'h00;
    x = 1'b0;
    for (k = 0; k < 4000 && i_tx_line !== 1'b0; k++)
      @(posedge i_core_clk);
    repeat (BIT_CLKS / 2) @(posedge i_core_clk);
    for (int i = 0; i < n + 32'(hx); i++)
    begin
      repeat (BIT_CLKS) @(posedge i_core_clk);
      if (i < n)
        d[i] = i_tx_line;
      else
        x = i_tx_line;
    end
    repeat (BIT_CLKS) @(posedge i_core_clk);
    stop = i_tx_line;
  endtask : recv
endmodule : uart_remote_end
`default_nettype wire

// [testbench/tb.sv]
// self-checking bench for the channel mode control block
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int BITS = 16;
  localparam logic [47:0] TX_MODES = 48'h00_05_0E_12_1B_1F;
  // block mode keeps flags of characters already popped
  localparam logic [17:0] ERR_EXP = {9'b111_111_001, 9'b000_110_001};
  logic clk, rstn, cs_n, rd_n, wr_n, rx, tx, cts_n, rts_n, pin4_n, irq;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  int err_count, n_tests;
  uart_channel_mode_control #(.BIT_CLKS(BITS), .FIFO_DEPTH(8)) uart_channel_mode_control_inst (
    .i_core_clk(clk), .i_rstn(rstn), .i_chip_sel_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n),
    .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .i_rx_line(rx), .o_tx_line(tx),
    .i_clear_to_send_in_n(cts_n), .o_request_to_send_out_n(rts_n),
    .o_output_pin_four_n(pin4_n), .o_rx_irq(irq));
  uart_remote_end #(.BIT_CLKS(BITS)) far (.i_core_clk(clk), .i_tx_line(tx), .o_rx_line(rx),
    .o_cts_n(cts_n));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    {cs_n, wr_n, addr, wdata} <= {2'b00, a, d};
    @(posedge clk);
    {cs_n, wr_n} <= 2'b11;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    {cs_n, rd_n, addr} <= {2'b00, a};
    @(posedge clk);
    {cs_n, rd_n} <= 2'b11;
    #1 d = rdata;
  endtask : rd
  task automatic cmd(input logic [7:0] d);
    wr(uart_channel_pkg::ADDR_COMMAND, d);
  endtask : cmd
  task automatic set_mode1(input logic [7:0] m);
    cmd(8'h10);
    wr(uart_channel_pkg::ADDR_MODE, m);
  endtask : set_mode1
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  task automatic t_pointer;
    logic [7:0] v;
    rd(uart_channel_pkg::ADDR_MODE, v);
    chk("first mode reset", uart_channel_pkg::MODE_RESET, v);
    rd(uart_channel_pkg::ADDR_MODE, v);
    chk("second mode reset", uart_channel_pkg::MODE_RESET, v);
    set_mode1(8'h5A);
    wr(uart_channel_pkg::ADDR_MODE, 8'h0F);
    rd(uart_channel_pkg::ADDR_MODE, v);
    chk("second mode", 8'h0F, v);
    cmd(8'h10);
    rd(uart_channel_pkg::ADDR_MODE, v);
    chk("first mode", 8'h5A, v);
    rd(uart_channel_pkg::ADDR_MODE, v);
    chk("second again", 8'h0F, v);
    $display("pointer test done");
  endtask : t_pointer
  task automatic t_tx;
    logic [7:0] m, d, mask;
    logic x, s, xe, hx;
    cmd(8'h04);
    for (int i = 0; i < 6; i++)
    begin
      m = TX_MODES[i*8 +: 8];
      mask = 8'hFF >> (3 - m[1:0]);
      hx = m[4:3] != uart_channel_pkg::PAR_NONE;
      xe = (m[4:3] == uart_channel_pkg::PAR_WITH) ? (^(8'hB6 & mask)) ^ m[2] : m[2];
      set_mode1(m);
      wr(uart_channel_pkg::ADDR_HOLDING, 8'hB6);
      far.recv(int'(m[1:0]) + 5, hx, d, x, s);
      chk("tx data", 8'hB6 & mask, d);
      chk("tx extra bit", {7'h0, hx & xe}, {7'h0, x});
      chk("tx stop", 8'h01, {7'h0, s});
      repeat (BITS) @(posedge clk);
    end
    $display("transmit test done");
  endtask : t_tx
  task automatic t_multidrop;
    logic [7:0] v;
    set_mode1(8'h1B);
    far.send(8'h11, 8, 1'b1, 1'b0, 1'b1);
    far.send(8'h22, 8, 1'b1, 1'b1, 1'b1);
    settle;
    chk("ready irq", 8'h01, {7'h0, irq});
    rd(uart_channel_pkg::ADDR_STATUS_BAUD, v);
    chk("address status", 8'h21, v & 8'h23);
    rd(uart_channel_pkg::ADDR_HOLDING, v);
    chk("address char", 8'h22, v);
    rd(uart_channel_pkg::ADDR_STATUS_BAUD, v);
    chk("fifo empty", 8'h00, v & 8'h01);
    $display("multidrop test done");
  endtask : t_multidrop
  task automatic t_flow;
    logic [7:0] v;
    cmd(8'h20);
    cmd(8'h01);
    wr(uart_channel_pkg::ADDR_SET_OUT, 8'h01);
    settle;
    chk("rts on", 8'h00, {7'h0, rts_n});
    wr(uart_channel_pkg::ADDR_PIN_CONFIG, 8'h10);
    set_mode1(8'hD3);
    for (int k = 0; k < 8; k++)
    begin
      far.send(8'h30 + 8'(k), 8, 1'b0, 1'b0, 1'b1);
      settle;
      chk("full irq", {7'h0, k == 7}, {7'h0, irq});
      chk("pin four", {7'h0, k != 7}, {7'h0, pin4_n});
    end
    chk("rts before start", 8'h00, {7'h0, rts_n});
    far.send(8'h38, 8, 1'b0, 1'b0, 1'b1);
    chk("rts auto off", 8'h01, {7'h0, rts_n});
    rd(uart_channel_pkg::ADDR_HOLDING, v);
    chk("first char", 8'h30, v);
    settle;
    chk("rts auto on", 8'h00, {7'h0, rts_n});
    wr(uart_channel_pkg::ADDR_CLR_OUT, 8'h01);
    settle;
    chk("rts off", 8'h01, {7'h0, rts_n});
    cmd(8'h20);
    $display("flow control test done");
  endtask : t_flow
  task automatic t_errors;
    logic [7:0] v;
    cmd(8'h01);
    for (int j = 0; j < 2; j++)
    begin
      set_mode1(j == 1 ? 8'h23 : 8'h03);
      cmd(8'h40);
      far.send(8'h55, 8, 1'b1, 1'b1, 1'b1);
      far.send(8'h00, 8, 1'b1, 1'b0, 1'b0);
      far.send(8'h0F, 8, 1'b1, 1'b0, 1'b1);
      for (int k = 0; k < 3; k++)
      begin
        rd(uart_channel_pkg::ADDR_STATUS_BAUD, v);
        chk("error flags", {5'h0, ERR_EXP[j*9+k*3 +: 3]}, {5'h0, v[7:5]});
        rd(uart_channel_pkg::ADDR_HOLDING, v);
      end
    end
    cmd(8'h40);
    rd(uart_channel_pkg::ADDR_STATUS_BAUD, v);
    chk("flags cleared", 8'h00, {5'h0, v[7:5]});
    // disable both directions: transmitter idle, so empty but not ready
    cmd(8'h0A);
    rd(uart_channel_pkg::ADDR_STATUS_BAUD, v);
    chk("tx disabled", 8'h08, v & 8'h0C);
    $display("error mode test done");
  endtask : t_errors
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test
  initial
  begin
    {rstn, cs_n, rd_n, wr_n, addr, wdata} = {4'b0111, 4'h0, 8'h00};
    err_count = 0;
    n_tests = 0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_pointer;
    t_tx;
    t_multidrop;
    t_flow;
    t_errors;
    finish_test;
  end
  initial
  begin
    repeat (30000) @(posedge clk);
    err_count++;
    finish_test;
  end
endmodule : tb
`default_nettype wire
